// ---- smpi_lib.sv ----
`timescale 1ns/100ps
module smpi_sync #(
	parameter int W = 1
) (
	input wire logic i_clk_sys,
	input wire logic i_resetn,
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);
	logic [W-1:0] meta;
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			meta <= '1;
			o_sync <= '1;
		end else begin
			meta <= i_async;
			o_sync <= meta;
		end
	end
endmodule : smpi_sync

module smpi_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 8
) (
	input wire logic i_clk_sys,
	input wire logic i_resetn,
	input wire logic [W-1:0] i_data,
	input wire logic i_valid,
	output logic o_ready,
	output logic [W-1:0] o_data,
	output logic o_valid,
	input wire logic i_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wp;
	logic [AW-1:0] rp;
	logic [AW:0] count;
	logic [AW:0] next_count;
	logic push;
	logic pop;
	assign push = i_valid && o_ready;
	assign pop = o_valid && i_ready;
	assign o_valid = (count != '0);
	assign o_data = mem[rp];
	always_comb begin
		next_count = count;
		if (push && !pop) begin
			next_count = count + 1'b1;
		end else if (pop && !push) begin
			next_count = count - 1'b1;
		end
	end
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			wp <= '0;
			rp <= '0;
			count <= '0;
			o_ready <= 1'b0;
		end else begin
			count <= next_count;
			o_ready <= (next_count != (AW+1)'(DEPTH));
			if (push) begin
				wp <= wp + 1'b1;
			end
			if (pop) begin
				rp <= rp + 1'b1;
			end
		end
	end
	always_ff @(posedge i_clk_sys) begin
		if (push) begin
			mem[wp] <= i_data;
		end
	end
endmodule : smpi_fifo

module smpi_uart_tx
	import smpi_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_resetn,
	input wire logic [7:0] i_data,
	input wire logic i_valid,
	input wire logic i_hold,
	output logic o_ready,
	output logic o_tx
);
	smpi_tx_e state;
	logic [8:0] sh;
	logic [3:0] bitn;
	logic [11:0] cnt;
	// Ready lags the hold input by one cycle; a taken byte is always sent whole
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			state <= SMPI_TX_IDLE;
			sh <= '1;
			bitn <= 4'h0;
			cnt <= 12'h000;
			o_ready <= 1'b0;
			o_tx <= 1'b1;
		end else begin
			case (state)
				SMPI_TX_IDLE: begin
					o_tx <= 1'b1;
					if (i_valid && o_ready) begin
						state <= SMPI_TX_SHIFT;
						o_ready <= 1'b0;
						o_tx <= 1'b0;
						sh <= {1'b1, i_data};
						bitn <= 4'h9;
						cnt <= BIT_CYC - 12'h001;
					end else begin
						o_ready <= !i_hold;
					end
				end
				SMPI_TX_SHIFT: begin
					if (cnt != 12'h000) begin
						cnt <= cnt - 12'h001;
					end else if (bitn == 4'h0) begin
						state <= SMPI_TX_IDLE;
						o_ready <= !i_hold;
					end else begin
						o_tx <= sh[0];
						sh <= {1'b1, sh[8:1]};
						bitn <= bitn - 4'h1;
						cnt <= BIT_CYC - 12'h001;
					end
				end
				default: begin
					state <= SMPI_TX_IDLE;
				end
			endcase
		end
	end
endmodule : smpi_uart_tx

module smpi_uart_rx
	import smpi_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_resetn,
	input wire logic i_rx,
	output logic [7:0] o_data,
	output logic o_valid
);
	smpi_rx_e state;
	logic [7:0] sh;
	logic [2:0] bitn;
	logic [11:0] cnt;
	// A frame whose stop bit reads low is dropped silently
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			state <= SMPI_RX_IDLE;
			sh <= 8'h00;
			bitn <= 3'h0;
			cnt <= 12'h000;
			o_data <= 8'h00;
			o_valid <= 1'b0;
		end else begin
			o_valid <= 1'b0;
			if (cnt != 12'h000) begin
				cnt <= cnt - 12'h001;
			end else begin
				case (state)
					SMPI_RX_IDLE: begin
						if (!i_rx) begin
							state <= SMPI_RX_START;
							cnt <= HALF_CYC - 12'h001;
						end
					end
					SMPI_RX_START: begin
						state <= i_rx ? SMPI_RX_IDLE : SMPI_RX_DATA;
						bitn <= 3'h0;
						cnt <= BIT_CYC - 12'h001;
					end
					SMPI_RX_DATA: begin
						sh <= {i_rx, sh[7:1]};
						bitn <= bitn + 3'h1;
						cnt <= BIT_CYC - 12'h001;
						if (bitn == 3'h7) begin
							state <= SMPI_RX_STOP;
						end
					end
					SMPI_RX_STOP: begin
						state <= SMPI_RX_IDLE;
						if (i_rx) begin
							o_data <= sh;
							o_valid <= 1'b1;
						end
					end
					default: begin
						state <= SMPI_RX_IDLE;
					end
				endcase
			end
		end
	end
endmodule : smpi_uart_rx

// ---- smpi_pkg.sv ----
package smpi_pkg;
	// 40 MHz system clock
	localparam int CLK_HZ = 32'h0262_5A00;
	localparam int CLK_PERIOD_NS = 32'h0000_0019;
	// 115200 baud
	localparam int BAUD_RATE = 32'h0001_C200;
	localparam logic [11:0] BIT_CYC = 12'(CLK_HZ / BAUD_RATE);
	localparam logic [11:0] HALF_CYC = 12'(CLK_HZ / BAUD_RATE / 2);
	// Link indicator dark time per received packet, 10000 ns
	localparam int LINK_BLINK_NS = 32'h0000_2710;
	localparam logic [8:0] LINK_BLINK_CYC = 9'(LINK_BLINK_NS / CLK_PERIOD_NS);
	// Least hold time of the module reset pin, 50 ms
	localparam int RST_HOLD_MS = 32'h0000_0032;
	localparam int RST_HOLD_CYC = RST_HOLD_MS * (CLK_HZ / 1000);
	localparam int FIFO_DEPTH = 32'h0000_0008;
	localparam int DATA_W = 32'h0000_0008;
	// Bit positions of the general-purpose lines in the pin vectors
	localparam int GPIO_LINE_TWO = 0;
	localparam int GPIO_LINE_THREE = 1;
	localparam int GPIO_LINE_FOUR = 2;
	localparam int GPIO_LINE_FIVE = 3;
	localparam logic [3:0] GPIO_RELEASED = 4'hF;
	localparam logic [3:0] GPIO_SINK = 4'h0;
	typedef enum logic [0:0] {
		SMPI_TX_IDLE = 1'b0,
		SMPI_TX_SHIFT = 1'b1
	} smpi_tx_e;
	typedef enum logic [1:0] {
		SMPI_RX_IDLE = 2'b00,
		SMPI_RX_START = 2'b01,
		SMPI_RX_DATA = 2'b10,
		SMPI_RX_STOP = 2'b11
	} smpi_rx_e;
endpackage : smpi_pkg

// ---- smpi_if.sv ----
`timescale 1ns/100ps
interface smpi_if;
	logic [3:0] dev_gpio_out;
	logic [3:0] dev_gpio_oe_n;
	logic [3:0] host_gpio_out;
	logic [3:0] host_gpio_oe_n;
	logic [3:0] gpio_level;
	logic tx_line;
	logic rx_line;
	logic reset_pin;
	logic mode_select_pin;
	logic led_output_three;
	logic led_output_four;
	logic link_led;
	logic speed_led;
	// Weak pull-up: a line is low only when some enabled driver sinks it
	assign gpio_level = ~((~dev_gpio_oe_n & ~dev_gpio_out) | (~host_gpio_oe_n & ~host_gpio_out));
	modport dev (
		input gpio_level, rx_line, reset_pin, mode_select_pin,
		output dev_gpio_out, dev_gpio_oe_n, tx_line,
		output led_output_three, led_output_four, link_led, speed_led
	);
	modport host (
		input gpio_level, tx_line, led_output_three, led_output_four, link_led, speed_led,
		output host_gpio_out, host_gpio_oe_n, rx_line, reset_pin, mode_select_pin
	);
endinterface : smpi_if

// ---- smpi_dev.sv ----
`timescale 1ns/100ps
// Function
// - Lines sink low only, weak pull-up high
// - No direction control; latch value decides
// - Latch high before a line is read
// - Host may pull a high line low
// - Serial idles high, low start, high stop
// - Handshake low allows, high forbids sending
// - Line five is request-to-send in full duplex
// - Line five is direction control in half duplex
// - Line four is clear-to-send and duplex select
// - Line three terminal ready, two set ready
// - Mode pin at power-up picks application or upgrade
// - Mode pin low while running requests programming; code raises o_prog_req only after an application boot
// - Host holds reset high at least 50 ms
// - Host pin may hold reset and release it
// - Link lamp on, dark briefly per packet
// - Speed lamp on at 100Mb, off at 10Mb
// - Lamp outputs three green, four red status
module smpi_dev
	import smpi_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_resetn,
	smpi_if.dev pins,
	input wire logic [7:0] i_tx_data,
	input wire logic i_tx_valid,
	output logic o_tx_ready,
	output logic [7:0] o_rx_data,
	output logic o_rx_valid,
	input wire logic i_rx_ready,
	input wire logic i_serial_en,
	input wire logic [3:0] i_gpio_latch,
	output logic [3:0] o_gpio_in,
	input wire logic i_dtr_n,
	output logic o_dsr_n,
	output logic o_cts_ok,
	input wire logic i_link_up,
	input wire logic i_speed_100,
	input wire logic i_pkt_rx,
	input wire logic i_status_green,
	input wire logic i_status_red,
	output logic o_in_reset,
	output logic o_boot_app,
	output logic o_boot_done,
	output logic o_full_duplex,
	output logic o_prog_req
);
	logic [6:0] pin_sync;
	logic [3:0] gpio_s;
	logic rx_s;
	logic rst_pin_s;
	logic md_s;
	logic rst_pin_d;
	logic run;
	logic [7:0] fifo_data;
	logic fifo_valid;
	logic tx_ready;
	logic tx_hold;
	logic cts_allow;
	logic [3:0] next_latch;
	logic [8:0] blink_cnt;

	smpi_sync #(
		.W(7)
	) u_sync (
		.i_clk_sys(i_clk_sys),
		.i_resetn(i_resetn),
		.i_async({pins.mode_select_pin, pins.reset_pin, pins.rx_line, pins.gpio_level}),
		.o_sync(pin_sync)
	);
	assign gpio_s = pin_sync[3:0];
	assign rx_s = pin_sync[4];
	assign rst_pin_s = pin_sync[5];
	assign md_s = pin_sync[6];
	assign run = !rst_pin_s;

	// Reset pin is active high and held by the host
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			rst_pin_d <= 1'b1;
			o_in_reset <= 1'b1;
		end else begin
			rst_pin_d <= rst_pin_s;
			o_in_reset <= rst_pin_s;
		end
	end

	// Lines are all released during reset, so line four and the mode pin read the host
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			o_boot_app <= 1'b0;
			o_boot_done <= 1'b0;
			o_full_duplex <= 1'b1;
		end else if (rst_pin_s) begin
			o_boot_done <= 1'b0;
		end else if (rst_pin_d) begin
			o_boot_app <= md_s;
			o_full_duplex <= gpio_s[GPIO_LINE_FOUR];
			o_boot_done <= 1'b1;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			o_prog_req <= 1'b0;
		end else begin
			o_prog_req <= run && o_boot_done && o_boot_app && !md_s;
		end
	end

	assign cts_allow = !i_serial_en || !o_full_duplex || !gpio_s[GPIO_LINE_FOUR];
	assign tx_hold = !run || !cts_allow;

	smpi_fifo #(
		.W(DATA_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.i_clk_sys(i_clk_sys),
		.i_resetn(i_resetn),
		.i_data(i_tx_data),
		.i_valid(i_tx_valid),
		.o_ready(o_tx_ready),
		.o_data(fifo_data),
		.o_valid(fifo_valid),
		.i_ready(tx_ready)
	);

	smpi_uart_tx u_tx (
		.i_clk_sys(i_clk_sys),
		.i_resetn(i_resetn),
		.i_data(fifo_data),
		.i_valid(fifo_valid),
		.i_hold(tx_hold),
		.o_ready(tx_ready),
		.o_tx(pins.tx_line)
	);

	smpi_uart_rx u_rx (
		.i_clk_sys(i_clk_sys),
		.i_resetn(i_resetn),
		.i_rx(rx_s),
		.o_data(o_rx_data),
		.o_valid(o_rx_valid)
	);

	// A high latch only releases the line; there is no separate direction bit
	always_comb begin
		next_latch = i_gpio_latch;
		if (i_serial_en) begin
			next_latch[GPIO_LINE_TWO] = 1'b1;
			next_latch[GPIO_LINE_THREE] = i_dtr_n;
			next_latch[GPIO_LINE_FOUR] = 1'b1;
			if (o_full_duplex) begin
				next_latch[GPIO_LINE_FIVE] = !i_rx_ready;
			end else begin
				next_latch[GPIO_LINE_FIVE] = !tx_ready;
			end
		end
		if (rst_pin_s) begin
			next_latch = GPIO_RELEASED;
		end
	end

	assign pins.dev_gpio_out = GPIO_SINK;
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			pins.dev_gpio_oe_n <= GPIO_RELEASED;
		end else begin
			pins.dev_gpio_oe_n <= next_latch;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			o_gpio_in <= GPIO_RELEASED;
			o_dsr_n <= 1'b1;
			o_cts_ok <= 1'b0;
		end else begin
			o_gpio_in <= gpio_s;
			o_dsr_n <= gpio_s[GPIO_LINE_TWO];
			o_cts_ok <= !gpio_s[GPIO_LINE_FOUR];
		end
	end

	// Blink restarts on every packet, so steady traffic keeps the lamp mostly dark
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			blink_cnt <= 9'h000;
		end else if (i_pkt_rx) begin
			blink_cnt <= LINK_BLINK_CYC;
		end else if (blink_cnt != 9'h000) begin
			blink_cnt <= blink_cnt - 9'h001;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			pins.link_led <= 1'b0;
			pins.speed_led <= 1'b0;
			pins.led_output_three <= 1'b0;
			pins.led_output_four <= 1'b0;
		end else begin
			pins.link_led <= i_link_up && !i_pkt_rx && (blink_cnt == 9'h000);
			pins.speed_led <= i_link_up && i_speed_100;
			pins.led_output_three <= i_status_green;
			pins.led_output_four <= i_status_red;
		end
	end
endmodule : smpi_dev

// ---- smpi_host.sv ----
`timescale 1ns/100ps
module smpi_host
	import smpi_pkg::*;
#(
	parameter int RST_HOLD = RST_HOLD_CYC
) (
	input wire logic i_clk_sys,
	input wire logic i_resetn,
	smpi_if.host pins,
	input wire logic [7:0] i_tx_data,
	input wire logic i_tx_valid,
	output logic o_tx_ready,
	output logic [7:0] o_rx_data,
	output logic o_rx_valid,
	input wire logic i_hold_reset,
	input wire logic i_mode_select,
	input wire logic i_half_duplex,
	input wire logic i_dev_may_send,
	input wire logic i_dsr_n,
	output logic o_dev_released,
	output logic o_rts_ok,
	output logic o_dtr_n,
	output logic [3:0] o_gpio_in
);
	logic [4:0] pin_sync;
	logic [3:0] gpio_s;
	logic tx_s;
	logic [31:0] hold_cnt;
	logic tx_hold;
	logic [3:0] next_latch;

	smpi_sync #(
		.W(5)
	) u_sync (
		.i_clk_sys(i_clk_sys),
		.i_resetn(i_resetn),
		.i_async({pins.tx_line, pins.gpio_level}),
		.o_sync(pin_sync)
	);
	assign gpio_s = pin_sync[3:0];
	assign tx_s = pin_sync[4];

	// Reset pin stays high from our own reset until the hold count runs out
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			hold_cnt <= 32'h0000_0000;
			pins.reset_pin <= 1'b1;
			o_dev_released <= 1'b0;
		end else begin
			if (i_hold_reset) begin
				hold_cnt <= 32'h0000_0000;
			end else if (hold_cnt != 32'(RST_HOLD)) begin
				hold_cnt <= hold_cnt + 32'h0000_0001;
			end
			pins.reset_pin <= i_hold_reset || (hold_cnt != 32'(RST_HOLD));
			o_dev_released <= !i_hold_reset && (hold_cnt == 32'(RST_HOLD));
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			pins.mode_select_pin <= 1'b1;
		end else begin
			pins.mode_select_pin <= i_mode_select;
		end
	end

	always_comb begin
		next_latch = GPIO_RELEASED;
		next_latch[GPIO_LINE_TWO] = i_dsr_n;
		if (pins.reset_pin) begin
			next_latch[GPIO_LINE_FOUR] = !i_half_duplex;
		end else begin
			next_latch[GPIO_LINE_FOUR] = !i_dev_may_send;
		end
	end

	assign pins.host_gpio_out = GPIO_SINK;
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			pins.host_gpio_oe_n <= GPIO_RELEASED;
			o_gpio_in <= GPIO_RELEASED;
			o_rts_ok <= 1'b0;
			o_dtr_n <= 1'b1;
		end else begin
			pins.host_gpio_oe_n <= next_latch;
			o_gpio_in <= gpio_s;
			o_rts_ok <= !gpio_s[GPIO_LINE_FIVE];
			o_dtr_n <= gpio_s[GPIO_LINE_THREE];
		end
	end

	assign tx_hold = pins.reset_pin || (!i_half_duplex && gpio_s[GPIO_LINE_FIVE]);

	smpi_uart_tx u_tx (
		.i_clk_sys(i_clk_sys),
		.i_resetn(i_resetn),
		.i_data(i_tx_data),
		.i_valid(i_tx_valid),
		.i_hold(tx_hold),
		.o_ready(o_tx_ready),
		.o_tx(pins.rx_line)
	);

	smpi_uart_rx u_rx (
		.i_clk_sys(i_clk_sys),
		.i_resetn(i_resetn),
		.i_rx(tx_s),
		.o_data(o_rx_data),
		.o_valid(o_rx_valid)
	);
endmodule : smpi_host

// ---- smpi_sva.sv ----
`timescale 1ns/100ps
module smpi_sva
	import smpi_pkg::*;
#(
	parameter int RST_HOLD = 20
) (
	input wire logic i_clk_sys,
	input wire logic i_resetn,
	input wire logic [3:0] dev_gpio_out,
	input wire logic [3:0] dev_gpio_oe_n,
	input wire logic [3:0] host_gpio_out,
	input wire logic [3:0] host_gpio_oe_n,
	input wire logic [3:0] gpio_level,
	input wire logic tx_line,
	input wire logic rx_line,
	input wire logic reset_pin
);
	logic [11:0] tx_lo;
	logic [11:0] tx_hi;
	logic [11:0] rx_lo;
	logic [11:0] rx_hi;
	int rst_hi;
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_resetn);
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			tx_lo <= 12'h000;
			rx_lo <= 12'h000;
			// An idle line counts as a finished stop bit
			tx_hi <= BIT_CYC;
			rx_hi <= BIT_CYC;
		end else begin
			tx_lo <= tx_line ? 12'h000 : tx_lo + 12'h001;
			rx_lo <= rx_line ? 12'h000 : rx_lo + 12'h001;
			tx_hi <= !tx_line ? 12'h000 : tx_hi + 12'(tx_hi != 12'hFFF);
			rx_hi <= !rx_line ? 12'h000 : rx_hi + 12'(rx_hi != 12'hFFF);
		end
	end
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			rst_hi <= 0;
		end else begin
			rst_hi <= reset_pin ? rst_hi + 1 : 0;
		end
	end
	property p_dev_sink;
		dev_gpio_out == 4'h0;
	endproperty
	a_dev_sink: assert property (p_dev_sink) else $error("device drives a line high");
	property p_host_sink;
		host_gpio_out == 4'h0;
	endproperty
	a_host_sink: assert property (p_host_sink) else $error("host drives a line high");
	property p_pull_up;
		(dev_gpio_oe_n & host_gpio_oe_n & ~gpio_level) == 4'h0;
	endproperty
	a_pull_up: assert property (p_pull_up) else $error("released line reads low");
	property p_host_wins;
		(~host_gpio_oe_n & gpio_level) == 4'h0;
	endproperty
	a_host_wins: assert property (p_host_wins) else $error("host sink not seen on line");
	property p_release;
		reset_pin [*5] |-> dev_gpio_oe_n == 4'hF;
	endproperty
	a_release: assert property (p_release) else $error("line sunk during reset");
	property p_tx_low_run;
		$rose(tx_line) |-> tx_lo != 12'h000 && tx_lo % BIT_CYC == 12'h000 && tx_lo <= 9 * BIT_CYC;
	endproperty
	a_tx_low_run: assert property (p_tx_low_run) else $error("bad low run on tx");
	property p_tx_stop;
		$fell(tx_line) |-> tx_hi >= BIT_CYC;
	endproperty
	a_tx_stop: assert property (p_tx_stop) else $error("short high run on tx");
	property p_rx_low_run;
		$rose(rx_line) |-> rx_lo != 12'h000 && rx_lo % BIT_CYC == 12'h000 && rx_lo <= 9 * BIT_CYC;
	endproperty
	a_rx_low_run: assert property (p_rx_low_run) else $error("bad low run on rx");
	property p_rx_stop;
		$fell(rx_line) |-> rx_hi >= BIT_CYC;
	endproperty
	a_rx_stop: assert property (p_rx_stop) else $error("short high run on rx");
	property p_hold;
		$fell(reset_pin) |-> rst_hi >= RST_HOLD;
	endproperty
	a_hold: assert property (p_hold) else $error("reset pin released early");
	property p_rst_stays;
		$rose(reset_pin) |-> reset_pin [*8];
	endproperty
	a_rst_stays: assert property (p_rst_stays) else $error("reset pin pulse too short");
endmodule : smpi_sva

// ---- tb_serial_module_pin_interface.sv ----
`timescale 1ns/100ps
module tb_serial_module_pin_interface;
	logic clk = 1'h0;
	logic rstn = 1'h0;
	logic [7:0] d_txd = 8'h00;
	logic d_txv = 1'h0;
	logic d_rxr = 1'h1;
	logic ser = 1'h1;
	logic [3:0] latch = 4'hF;
	logic dtr_n = 1'h1;
	logic link = 1'h0;
	logic spd = 1'h0;
	logic pkt = 1'h0;
	logic grn = 1'h0;
	logic red = 1'h0;
	logic [7:0] h_txd = 8'h00;
	logic h_txv = 1'h0;
	logic hold = 1'h0;
	logic mode = 1'h1;
	logic half = 1'h0;
	logic may = 1'h1;
	logic dsr_n = 1'h1;
	logic d_txr, d_rxv, dsr_o, cts, inrst, app, full, prog, done;
	logic h_txr, h_rxv, rel, rts, dtr_o;
	logic [7:0] d_rxd, h_rxd;
	logic [3:0] d_gin, h_gin;
	int n_fail = 0;
	int checks_done = 0;
	smpi_if smpi_if_inst();
	smpi_dev smpi_dev_inst(.i_clk_sys(clk), .i_resetn(rstn), .pins(smpi_if_inst.dev),
		.i_tx_data(d_txd), .i_tx_valid(d_txv), .o_tx_ready(d_txr), .o_rx_data(d_rxd),
		.o_rx_valid(d_rxv), .i_rx_ready(d_rxr), .i_serial_en(ser), .i_gpio_latch(latch),
		.o_gpio_in(d_gin), .i_dtr_n(dtr_n), .o_dsr_n(dsr_o), .o_cts_ok(cts), .i_link_up(link),
		.i_speed_100(spd), .i_pkt_rx(pkt), .i_status_green(grn), .i_status_red(red),
		.o_in_reset(inrst), .o_boot_app(app), .o_boot_done(done), .o_full_duplex(full),
		.o_prog_req(prog));
	// Short reset hold keeps the run brief
	smpi_host #(.RST_HOLD(20)) smpi_host_inst(.i_clk_sys(clk), .i_resetn(rstn),
		.pins(smpi_if_inst.host), .i_tx_data(h_txd), .i_tx_valid(h_txv), .o_tx_ready(h_txr),
		.o_rx_data(h_rxd), .o_rx_valid(h_rxv), .i_hold_reset(hold), .i_mode_select(mode),
		.i_half_duplex(half), .i_dev_may_send(may), .i_dsr_n(dsr_n), .o_dev_released(rel),
		.o_rts_ok(rts), .o_dtr_n(dtr_o), .o_gpio_in(h_gin));
	smpi_sva #(.RST_HOLD(20)) smpi_sva_inst(.i_clk_sys(clk), .i_resetn(rstn),
		.dev_gpio_out(smpi_if_inst.dev_gpio_out), .dev_gpio_oe_n(smpi_if_inst.dev_gpio_oe_n),
		.host_gpio_out(smpi_if_inst.host_gpio_out),
		.host_gpio_oe_n(smpi_if_inst.host_gpio_oe_n), .gpio_level(smpi_if_inst.gpio_level),
		.tx_line(smpi_if_inst.tx_line),
		.rx_line(smpi_if_inst.rx_line), .reset_pin(smpi_if_inst.reset_pin));
	always #12.5 clk = ~clk;
	task conclude;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : conclude
	task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task tk(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask : tk
	task push(input bit at_dev, input logic [7:0] d);
		d_txd = d;
		h_txd = d;
		d_txv = at_dev;
		h_txv = !at_dev;
		for (int k = 0; k < 4000; k++) begin
			@(posedge clk);
			if (at_dev ? d_txr : h_txr) begin
				#2;
				d_txv = 1'h0;
				h_txv = 1'h0;
				return;
			end
		end
		chk("send timeout", 8'h00, 8'h01);
		conclude;
	endtask : push
	task rcv(input bit at_dev, input logic [7:0] e);
		for (int k = 0; k < 4000; k++) begin
			@(posedge clk);
			if (at_dev ? d_rxv : h_rxv) begin
				chk("rx byte", at_dev ? d_rxd : h_rxd, e);
				#2;
				return;
			end
		end
		chk("rx timeout", 8'h00, 8'h01);
		conclude;
	endtask : rcv
	task rel_wait(output int k);
		for (k = 0; k < 200; k++) begin
			tk(1);
			if (rel === 1'h1)
				return;
		end
		chk("release timeout", 8'h00, 8'h01);
		conclude;
	endtask : rel_wait
	task s_boot;
		int k;
		rel_wait(k);
		tk(4);
		chk("boot app", app, 1'h1);
		chk("boot done", done, 1'h1);
		chk("full duplex", full, 1'h1);
		chk("in reset", inrst, 1'h0);
		mode = 1'h0;
		tk(5);
		chk("prog req", prog, 1'h1);
		chk("boot kept", app, 1'h1);
		mode = 1'h1;
	endtask : s_boot
	task s_gpio;
		ser = 1'h0;
		may = 1'h0;
		tk(6);
		chk("pulled up", h_gin, 4'hF);
		latch = 4'hA;
		tk(6);
		chk("latch sinks", h_gin, 4'hA);
		latch = 4'hF;
		dsr_n = 1'h0;
		tk(6);
		chk("read low", d_gin, 4'hE);
		dsr_n = 1'h1;
		ser = 1'h1;
		may = 1'h1;
	endtask : s_gpio
	task s_dtr;
		for (int v = 0; v < 2; v++) begin
			dtr_n = v[0];
			dsr_n = v[0];
			tk(6);
			chk("dtr", dtr_o, v[0]);
			chk("dsr", dsr_o, v[0]);
		end
	endtask : s_dtr
	task s_led;
		link = 1'h1;
		grn = 1'h1;
		for (int v = 1; v >= 0; v--) begin
			spd = v[0];
			tk(3);
			chk("speed", smpi_if_inst.speed_led, v[0]);
		end
		chk("green", smpi_if_inst.led_output_three, 1'h1);
		chk("red", smpi_if_inst.led_output_four, 1'h0);
		grn = 1'h0;
		red = 1'h1;
		tk(3);
		chk("green off", smpi_if_inst.led_output_three, 1'h0);
		chk("red on", smpi_if_inst.led_output_four, 1'h1);
		chk("link on", smpi_if_inst.link_led, 1'h1);
		pkt = 1'h1;
		tk(1);
		pkt = 1'h0;
		tk(3);
		chk("link blink", smpi_if_inst.link_led, 1'h0);
		tk(420);
		chk("link back", smpi_if_inst.link_led, 1'h1);
		link = 1'h0;
		tk(3);
		chk("link gone", smpi_if_inst.link_led, 1'h0);
	endtask : s_led
	task s_fill;
		logic t;
		logic [7:0] n;
		logic [7:0] e;
		may = 1'h0;
		tk(6);
		chk("cts off", cts, 1'h0);
		n = 8'h00;
		d_txd = 8'h11;
		d_txv = 1'h1;
		for (int k = 0; k < 30; k++) begin
			@(posedge clk);
			t = d_txr;
			#2;
			if (t) begin
				n++;
				d_txd = d_txd + 8'h11;
			end
		end
		d_txv = 1'h0;
		chk("fifo depth", n, 8'h08);
		chk("tx held", smpi_if_inst.tx_line, 1'h1);
		may = 1'h1;
		e = 8'h11;
		for (int k = 0; k < 8; k++) begin
			rcv(1'b0, e);
			e = e + 8'h11;
		end
		chk("cts on", cts, 1'h1);
	endtask : s_fill
	task s_rts;
		int lows;
		d_rxr = 1'h0;
		tk(5);
		chk("rts off", rts, 1'h0);
		lows = 0;
		h_txd = 8'h3C;
		h_txv = 1'h1;
		for (int k = 0; k < 1000; k++) begin
			tk(1);
			lows += int'(smpi_if_inst.rx_line !== 1'h1);
		end
		chk("host held", 8'(lows != 0), 8'h00);
		d_rxr = 1'h1;
		push(1'b0, 8'h3C);
		rcv(1'b1, 8'h3C);
		chk("rts on", rts, 1'h1);
	endtask : s_rts
	task s_half;
		int k;
		half = 1'h1;
		mode = 1'h0;
		hold = 1'h1;
		tk(5);
		chk("held in reset", inrst, 1'h1);
		chk("boot cleared", done, 1'h0);
		hold = 1'h0;
		rel_wait(k);
		chk("hold time", 8'(k > 19), 8'h01);
		tk(4);
		chk("upgrade boot", app, 1'h0);
		chk("half duplex", full, 1'h0);
		chk("boot redone", done, 1'h1);
		mode = 1'h1;
		tk(5);
		chk("boot fixed", app, 1'h0);
		push(1'b1, 8'h5A);
		tk(1000);
		chk("dir sending", rts, 1'h0);
		rcv(1'b0, 8'h5A);
		tk(400);
		chk("dir idle", rts, 1'h1);
	endtask : s_half
	initial begin
		tk(12);
		rstn = 1'h1;
		s_boot;
		s_gpio;
		s_dtr;
		s_led;
		s_fill;
		s_rts;
		s_half;
		conclude;
	end
endmodule : tb_serial_module_pin_interface
